// >>> verilog/tws_pkg.sv
/*
  Shared constants for the three-wire serial EEPROM command block:
  array geometry, command encodings, input sampling slots and timing.
  Assumes one 50 MHz core clock; the serial clock arrives as a pin.
*/
package tws_pkg;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int WORDS = 256;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 9;
  localparam logic [4:0] ALEN_X16 = 5'h08;
  localparam logic [4:0] ALEN_X8 = 5'h09;
  localparam logic [4:0] DLEN_X16 = 5'h10;
  localparam logic [4:0] DLEN_X8 = 5'h08;
  localparam logic [WORD_W-1:0] ERASED = 16'hffff;

  // ----------------------------------------------------------------
  // Command encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] OPC_MISC = 2'h0;
  localparam logic [1:0] LEAD_ENABLE = 2'h3;
  localparam logic [1:0] LEAD_DISABLE = 2'h0;
  localparam logic [1:0] LEAD_FILL = 2'h1;
  localparam logic [1:0] LEAD_CLEAR = 2'h2;

  // ----------------------------------------------------------------
  // Pin sampling slots
  // ----------------------------------------------------------------
  localparam int PIN_N = 5;
  localparam int PIN_CS = 0;
  localparam int PIN_SK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_ORG = 3;
  localparam int PIN_VOK = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_NS = 10_000_000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_CNT_W = 20;

  typedef enum logic [2:0] {
    TWS_IDLE = 3'h0,
    TWS_OPC = 3'h1,
    TWS_ADDR = 3'h3,
    TWS_DATA = 3'h2,
    TWS_READ = 3'h6,
    TWS_HOLD = 3'h7
  } tws_state_t;

  typedef enum logic [2:0] {
    TWS_P_NONE = 3'h0,
    TWS_P_WRITE = 3'h1,
    TWS_P_ERASE = 3'h2,
    TWS_P_FILL = 3'h3,
    TWS_P_CLEAR = 3'h4
  } tws_pend_t;
endpackage

// >>> verilog/tws_eeprom.sv
/*
  Command decoder, programming-latch control and storage of a 4096-bit
  three-wire serial EEPROM, all run from core_clk.
  Assumes: chip_select, serial_clock, serial_in, word_width_select and
  supply_ok are asynchronous pins; serial_out is a tri-state pin whose
  wire level is resolved outside from serial_out_oe.
*/
`timescale 1ns/1ps
module tws_eeprom #(
  parameter int PROG_CYCLES = tws_pkg::PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic word_width_select,
  input wire logic supply_ok,
  output logic serial_out,
  output logic serial_out_oe
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Read word, left aligned so the shifter always sends its MSB first
  function automatic logic [15:0] tws_rd_align(input logic [15:0] w, input logic x16, input logic hi);
    if (x16)
      tws_rd_align = w;
    else if (hi)
      tws_rd_align = {w[15:8], 8'h00};
    else
      tws_rd_align = {w[7:0], 8'h00};
  endfunction

  // Word index of a byte or word address
  function automatic logic [7:0] tws_word_idx(input logic [8:0] a, input logic x16);
    tws_word_idx = x16 ? a[7:0] : a[8:1];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [tws_pkg::PIN_N-1:0] pin_s1_r;
  logic [tws_pkg::PIN_N-1:0] pin_s2_r;
  logic [tws_pkg::PIN_N-1:0] pin_s3_r;
  logic [tws_pkg::PIN_N-1:0] pin_f_r;
  wire [tws_pkg::PIN_N-1:0] pin_raw = {supply_ok, word_width_select, serial_in, serial_clock, chip_select};
  wire [tws_pkg::PIN_N-1:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
  wire [tws_pkg::PIN_N-1:0] pin_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_f_r);

  // A change counts only once the second and third stages agree
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_f_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= pin_nxt;
    end
  end

  wire cs_f = pin_f_r[tws_pkg::PIN_CS];
  wire cs_now = pin_nxt[tws_pkg::PIN_CS];
  wire cs_fall = cs_f & ~cs_now;
  wire sk_rise = pin_nxt[tws_pkg::PIN_SK] & ~pin_f_r[tws_pkg::PIN_SK];
  wire si_bit = pin_nxt[tws_pkg::PIN_SI];
  wire x16 = pin_f_r[tws_pkg::PIN_ORG];
  wire supply_good = pin_f_r[tws_pkg::PIN_VOK];
  // Rules act only on rising serial clock with chip select high
  wire sk_take = sk_rise & cs_now;

  // ----------------------------------------------------------------
  // Command registers and field decode
  // ----------------------------------------------------------------
  tws_pkg::tws_state_t state_r;
  tws_pkg::tws_pend_t pend_r;
  logic [4:0] cnt_r;
  logic [1:0] opc_r;
  logic [8:0] addr_r;
  logic [15:0] data_r;
  logic [15:0] shift_r;
  logic wen_r;
  logic show_r;
  logic busy_r;
  logic [tws_pkg::PROG_CNT_W-1:0] prog_cnt_r;
  logic prog_all_r;
  logic [7:0] prog_idx_r;
  logic [15:0] prog_val_r;
  logic [15:0] prog_mask_r;
  logic [15:0] mem_r [tws_pkg::WORDS];

  wire [4:0] alen = x16 ? tws_pkg::ALEN_X16 : tws_pkg::ALEN_X8;
  wire [4:0] dlen = x16 ? tws_pkg::DLEN_X16 : tws_pkg::DLEN_X8;
  wire [8:0] addr_nxt = {addr_r[7:0], si_bit};
  wire [1:0] lead_bits = x16 ? addr_nxt[7:6] : addr_nxt[8:7];
  wire addr_last = (state_r == tws_pkg::TWS_ADDR) && sk_take && (cnt_r == alen - 5'h01);
  wire data_last = (state_r == tws_pkg::TWS_DATA) && sk_take && (cnt_r == dlen - 5'h01);
  wire read_last = (state_r == tws_pkg::TWS_READ) && sk_take && (cnt_r == dlen - 5'h01);
  wire is_misc = opc_r == tws_pkg::OPC_MISC;
  wire en_hit = addr_last && is_misc && (lead_bits == tws_pkg::LEAD_ENABLE);
  wire dis_hit = addr_last && is_misc && (lead_bits == tws_pkg::LEAD_DISABLE);
  wire rd_hit = addr_last && (opc_r == tws_pkg::OPC_READ);
  // Wrapping increment at the active word size
  wire [8:0] addr_inc = x16 ? {1'b0, addr_r[7:0] + 8'h01} : addr_r + 9'h001;
  wire [15:0] rd_first = tws_rd_align(mem_r[tws_word_idx(addr_nxt, x16)], x16, addr_nxt[0]);
  wire [15:0] rd_next = tws_rd_align(mem_r[tws_word_idx(addr_inc, x16)], x16, addr_inc[0]);
  // Supply and latch both gate the start; a busy array refuses a second one
  wire prog_start = cs_fall && (state_r == tws_pkg::TWS_HOLD) && (pend_r != tws_pkg::TWS_P_NONE)
                    && wen_r && supply_good && !busy_r;
  wire prog_done = busy_r && (prog_cnt_r == '0);
  wire start_bit = (state_r == tws_pkg::TWS_IDLE) && sk_take && si_bit;

  // Pending operation chosen when the address field completes
  tws_pkg::tws_pend_t pend_dec;
  always_comb begin
    case (opc_r)
      tws_pkg::OPC_WRITE: pend_dec = tws_pkg::TWS_P_WRITE;
      tws_pkg::OPC_ERASE: pend_dec = tws_pkg::TWS_P_ERASE;
      tws_pkg::OPC_MISC: begin
        if (lead_bits == tws_pkg::LEAD_FILL)
          pend_dec = tws_pkg::TWS_P_FILL;
        else if (lead_bits == tws_pkg::LEAD_CLEAR)
          pend_dec = tws_pkg::TWS_P_CLEAR;
        else
          pend_dec = tws_pkg::TWS_P_NONE;
      end
      default: pend_dec = tws_pkg::TWS_P_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  // Only sampled serial-clock rises advance it, so a parked clock freezes it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= tws_pkg::TWS_IDLE;
      pend_r <= tws_pkg::TWS_P_NONE;
      cnt_r <= 5'h00;
      opc_r <= 2'h0;
      addr_r <= 9'h000;
      data_r <= 16'h0000;
      shift_r <= 16'h0000;
    end else if (!cs_now) begin
      state_r <= tws_pkg::TWS_IDLE;
      cnt_r <= 5'h00;
      if (!prog_start)
        pend_r <= tws_pkg::TWS_P_NONE;
    end else if (sk_take) begin
      case (state_r)
        tws_pkg::TWS_IDLE: begin
          if (si_bit) begin
            state_r <= tws_pkg::TWS_OPC;
            cnt_r <= 5'h00;
          end
        end
        tws_pkg::TWS_OPC: begin
          opc_r <= {opc_r[0], si_bit};
          cnt_r <= (cnt_r == 5'h01) ? 5'h00 : cnt_r + 5'h01;
          if (cnt_r == 5'h01)
            state_r <= tws_pkg::TWS_ADDR;
        end
        tws_pkg::TWS_ADDR: begin
          addr_r <= addr_nxt;
          cnt_r <= addr_last ? 5'h00 : cnt_r + 5'h01;
          if (addr_last) begin
            pend_r <= pend_dec;
            if (rd_hit) begin
              state_r <= tws_pkg::TWS_READ;
              shift_r <= rd_first;
            end else if (pend_dec == tws_pkg::TWS_P_WRITE || pend_dec == tws_pkg::TWS_P_FILL)
              state_r <= tws_pkg::TWS_DATA;
            else
              state_r <= tws_pkg::TWS_HOLD;
          end
        end
        tws_pkg::TWS_DATA: begin
          data_r <= {data_r[14:0], si_bit};
          cnt_r <= data_last ? 5'h00 : cnt_r + 5'h01;
          if (data_last)
            state_r <= tws_pkg::TWS_HOLD;
        end
        tws_pkg::TWS_READ: begin
          cnt_r <= read_last ? 5'h00 : cnt_r + 5'h01;
          if (read_last) begin
            addr_r <= addr_inc;
            shift_r <= rd_next;
          end else
            shift_r <= {shift_r[14:0], 1'b0};
        end
        tws_pkg::TWS_HOLD: state_r <= tws_pkg::TWS_HOLD;
        default: state_r <= tws_pkg::TWS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Programming latch, ready/busy and self-timed cycle
  // ----------------------------------------------------------------
  // Latch powers up closed; only the enable command opens it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      wen_r <= 1'b0;
    else if (en_hit)
      wen_r <= 1'b1;
    else if (dis_hit)
      wen_r <= 1'b0;
  end

  wire all_op = (pend_r == tws_pkg::TWS_P_FILL) || (pend_r == tws_pkg::TWS_P_CLEAR);
  wire erase_op = (pend_r == tws_pkg::TWS_P_ERASE) || (pend_r == tws_pkg::TWS_P_CLEAR);
  wire [7:0] tgt_idx = tws_word_idx(addr_r, x16);
  // Byte-wide data is replicated so the lane select below picks it up
  wire [15:0] new_val = erase_op ? tws_pkg::ERASED : (x16 ? data_r : {data_r[7:0], data_r[7:0]});
  wire [15:0] lane_mask = (x16 || all_op) ? 16'hffff : (addr_r[0] ? 16'hff00 : 16'h00ff);

  // Target is frozen at the start, so reads or refused commands while busy cannot move it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      show_r <= 1'b0;
      busy_r <= 1'b0;
      prog_cnt_r <= '0;
      prog_all_r <= 1'b0;
      prog_idx_r <= 8'h00;
      prog_val_r <= 16'h0000;
      prog_mask_r <= 16'h0000;
    end else begin
      if (prog_start) begin
        show_r <= 1'b1;
        busy_r <= 1'b1;
        prog_cnt_r <= tws_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
        prog_all_r <= all_op;
        prog_idx_r <= tgt_idx;
        prog_val_r <= new_val;
        prog_mask_r <= lane_mask;
      end else if (prog_done)
        busy_r <= 1'b0;
      else if (busy_r)
        prog_cnt_r <= prog_cnt_r - 1'b1;
      if (start_bit)
        show_r <= 1'b0; // Start bit hides the status again
    end
  end

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  // The new value replaces the old bits outright: erase-before-write is implied
  genvar gi;
  generate
    for (gi = 0; gi < tws_pkg::WORDS; gi++) begin : g_word
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset)
          mem_r[gi] <= tws_pkg::ERASED;
        else if (prog_done && (prog_all_r || prog_idx_r == 8'(gi)))
          mem_r[gi] <= (mem_r[gi] & ~prog_mask_r) | (prog_val_r & prog_mask_r);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Dummy zero first, then data on each taken rise; otherwise ready/busy
  wire status_on = cs_now && show_r && (state_r == tws_pkg::TWS_IDLE) && !start_bit;
  wire oe_nxt = cs_now && (status_on || rd_hit || state_r == tws_pkg::TWS_READ);
  wire so_nxt = rd_hit ? 1'b0
    : (state_r == tws_pkg::TWS_READ) ? (sk_take ? shift_r[15] : serial_out)
    : (status_on ? !busy_r : 1'b0);

  // Both pins come straight from flops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out <= so_nxt;
      serial_out_oe <= oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_FLOAT_DESELECTED: assert property (!cs_now |=> !serial_out_oe)
    else $error("serial_out driven while deselected");
  AST_LATCH_OPENS_ONLY_BY_CMD: assert property ($rose(wen_r) |-> $past(en_hit))
    else $error("programming latch opened without enable command");
  AST_START_NEEDS_GUARDS: assert property ($rose(busy_r) |-> $past(wen_r) && $past(supply_good) && $past(cs_fall))
    else $error("programming started without latch, supply or chip-select fall");
  AST_STATUS_SHOWN: assert property (status_on |=> serial_out_oe && serial_out == !$past(busy_r))
    else $error("ready/busy not shown on reselect");
  AST_DUMMY_ZERO: assert property (rd_hit |=> serial_out_oe && !serial_out)
    else $error("read did not lead with a zero bit");
  AST_READ_DECODE: assert property (rd_hit |=> state_r == tws_pkg::TWS_READ)
    else $error("read opcode not decoded");
  AST_BUSY_HOLDS: assert property (prog_start |=> busy_r [*8])
    else $error("busy dropped early");
  AST_CLEAR_ONES: assert property (prog_done && prog_all_r && prog_val_r == tws_pkg::ERASED |=>
    mem_r[0] == tws_pkg::ERASED && mem_r[tws_pkg::WORDS-1] == tws_pkg::ERASED)
    else $error("clear left bits at zero");
  AST_FROZEN_CLOCK: assert property (cs_f && cs_now && !sk_rise |=> $stable(state_r) && $stable(cnt_r))
    else $error("state moved without serial clock");
  AST_READ_ADVANCES: assert property (read_last && cs_now |=> addr_r == $past(addr_inc))
    else $error("sequential read did not advance");
  AST_ZEROS_IGNORED: assert property (state_r == tws_pkg::TWS_IDLE && sk_take && !si_bit
    |=> state_r == tws_pkg::TWS_IDLE)
    else $error("leading zero taken as start");

  CVR_READ_WRAP: cover property (read_last ##1 state_r == tws_pkg::TWS_READ);
  CVR_PROG_DONE: cover property (prog_done);
  CVR_STATUS_READY: cover property (status_on && !busy_r);
  CVR_ENABLE: cover property (en_hit);
endmodule // tws_eeprom

// >>> tb/tws_host.sv
/*
  Host controller model for the three-wire link of the serial EEPROM.
  Assumes the bench calls one task at a time, just after a core clock edge.
*/
`timescale 1ns/1ps
module tws_host (
  output logic chip_select,
  output logic serial_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // ----------------------------------------------------------------
  // Link timing and captured read data
  // ----------------------------------------------------------------
  localparam int HALF_NS = 80;
  logic rd_dummy;
  logic [15:0] rd [4];

  // Link idles with its clock stopped low and the chip deselected
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end

  // One link period; o is what the device showed just before this rise
  task automatic clk_bit(input logic b, output logic o);
    serial_in = b;
    #HALF_NS;
    o = serial_out_oe ? serial_out : 1'bx;
    serial_clock = 1'b1;
    #HALF_NS;
    serial_clock = 1'b0;
  endtask

  // Shift the low n bits of v, most significant first
  task automatic send(input logic [31:0] v, input int n);
    logic o;
    for (int i = n - 1; i >= 0; i--) begin
      clk_bit(v[i], o);
    end
  endtask

  // Two idle zeros, start bit, opcode, address, then data if any
  task automatic cmd(input logic [1:0] opc, input logic [8:0] adr, input int alen, input logic [15:0] dat,
                     input int dlen);
    chip_select = 1'b1;
    #HALF_NS;
    send({27'h000_0000, 3'h1, opc}, 5);
    send({23'h00_0000, adr}, alen);
    send({16'h0000, dat}, dlen);
  endtask

  // Deselect during clock low; data line no longer holds its last level
  task automatic end_frame();
    chip_select = 1'b0;
    serial_in = ~serial_in;
    #(4 * HALF_NS);
  endtask

  // Read nw words; clock may be parked low mid-word for pause_ns
  task automatic read(input logic [8:0] adr, input int alen, input int dlen, input int nw, input int pause_ns);
    logic o;
    cmd(2'h2, adr, alen, 16'h0000, 0);
    clk_bit(1'b0, rd_dummy);
    for (int w = 0; w < nw; w++) begin
      rd[w] = 16'h0000;
      for (int i = dlen - 1; i >= 0; i--) begin
        if (w == 0 && i == 3) begin
          #pause_ns;
        end
        clk_bit(1'b0, o);
        rd[w][i] = o;
      end
    end
    end_frame();
  endtask

  // Reselect without a start bit and sample status twice, then deselect
  task automatic status(output logic busy_v, output logic ready_v, output logic off_v, input int wait_ns);
    chip_select = 1'b1;
    serial_in = 1'b0;
    #200;
    busy_v = serial_out_oe ? serial_out : 1'bx;
    #wait_ns;
    ready_v = serial_out_oe ? serial_out : 1'bx;
    chip_select = 1'b0;
    #(4 * HALF_NS); // Keeps the minimum deselect time before the next frame
    off_v = serial_out_oe;
  endtask
endmodule // tws_host

// >>> tb/three_wire_serial_eeprom_tb.sv
/*
  Self-checking bench for the serial EEPROM command block.
  Assumes tws_host drives the link and the core clock runs at 50 MHz.
*/
`timescale 1ns/1ps
module three_wire_serial_eeprom_tb;
  // ----------------------------------------------------------------
  // Signals, expected array and counters
  // ----------------------------------------------------------------
  localparam int PROG = 50;
  localparam int SETTLE_NS = 1500;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic word_width_select = 1'b1;
  logic supply_ok = 1'b1;
  wire chip_select, serial_clock, serial_in, serial_out, serial_out_oe;
  int failures = 0;
  int comparisons = 0;
  int seed = 17;
  logic wen_m = 1'b0;
  logic [15:0] mem [256];
  logic [15:0] d;
  logic [8:0] a;
  logic b0, b1, b2;

  tws_eeprom #(.PROG_CYCLES(PROG)) DUT (.core_clk(core_clk), .reset(reset), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in), .word_width_select(word_width_select),
    .supply_ok(supply_ok), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  tws_host host (.chip_select(chip_select), .serial_clock(serial_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  always #10 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Checking, expectation and verdict helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Leading bits of the address field for the opcode-00 group
  function automatic logic [8:0] lead(input logic [1:0] l);
    return {1'b0, l, 6'h00};
  endfunction

  // Array as it should stand after one x16 programming command
  task automatic model(input logic [1:0] opc, input logic [7:0] adr, input logic [15:0] dat);
    if (opc == 2'h0 && adr[7:6] == 2'h3) begin
      wen_m = 1'b1;
    end else if (opc == 2'h0 && adr[7:6] == 2'h0) begin
      wen_m = 1'b0;
    end else if (wen_m && supply_ok) begin
      for (int i = 0; i < 256; i++) begin
        if (opc == 2'h0 || i == adr) begin
          mem[i] = (opc == 2'h1 || (opc == 2'h0 && adr[7:6] == 2'h1)) ? dat : 16'hFFFF;
        end
      end
    end
  endtask

  // x16 command, then wait out the self-timed cycle
  task automatic op(input logic [1:0] opc, input logic [8:0] adr, input logic [15:0] dat);
    host.cmd(opc, adr, 8, dat, (opc == 2'h1 || (opc == 2'h0 && adr[7:6] == 2'h1)) ? 16 : 0);
    host.end_frame();
    #SETTLE_NS;
    model(opc, adr[7:0], dat);
  endtask

  task automatic chk_read(input logic [7:0] adr, input int n, input int pause_ns);
    host.read({1'b0, adr}, 8, 16, n, pause_ns);
    check({15'h0000, host.rd_dummy}, 16'h0000);
    for (int w = 0; w < n; w++) begin
      check(host.rd[w], mem[8'(adr + w)]);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hFFFF;
    end
    repeat (16) @(posedge core_clk);
    #3;
    reset = 1'b0;
    repeat (6) @(posedge core_clk);
    #3;
    // Latch starts closed, so this write must not land
    op(2'h1, 9'h010, 16'h1234);
    chk_read(8'h10, 1, 0);
    done("power-up lock");
    op(2'h0, lead(2'h3), 16'h0000);
    host.cmd(2'h1, 9'h05A, 8, 16'hA5C3, 16);
    host.end_frame();
    host.status(b0, b1, b2, 1200);
    model(2'h1, 8'h5A, 16'hA5C3);
    check({15'h0000, b0}, 16'h0000);
    check({15'h0000, b1}, 16'h0001);
    check({15'h0000, b2}, 16'h0000);
    chk_read(8'h5A, 1, 0);
    done("status");
    // Overlapping bit patterns show whether the old word was erased first
    op(2'h1, 9'h033, 16'h00F0);
    op(2'h1, 9'h033, 16'h0F0F);
    chk_read(8'h33, 1, 0);
    for (int i = 0; i < 6; i++) begin
      a = 9'($random(seed)) & 9'h0FF;
      d = 16'($random(seed));
      op(2'h1, a, d);
      chk_read(a[7:0], 1, 0);
    end
    done("writes");
    supply_ok = 1'b0;
    #200;
    op(2'h1, 9'h033, 16'hBEEF);
    supply_ok = 1'b1;
    #200;
    chk_read(8'h33, 1, 0);
    op(2'h3, 9'h033, 16'h0000);
    chk_read(8'h32, 3, 0);
    // Deselect after four address bits; nothing may change
    host.cmd(2'h3, 9'h00A, 4, 16'h0000, 0);
    host.end_frame();
    #SETTLE_NS;
    chk_read(8'h5A, 1, 0);
    done("guards");
    op(2'h1, 9'h0FF, 16'($random(seed)));
    chk_read(8'hFF, 3, 2000);
    op(2'h0, lead(2'h1), 16'h6C39);
    chk_read(8'h80, 2, 0);
    op(2'h0, lead(2'h2), 16'h0000);
    chk_read(8'h7F, 2, 0);
    done("array");
    word_width_select = 1'b0;
    #200;
    host.cmd(2'h1, 9'h0B3, 9, 16'h005E, 8);
    host.end_frame();
    #SETTLE_NS;
    mem[8'h59][15:8] = 8'h5E;
    host.read(9'h0B3, 9, 8, 2, 0);
    check({8'h00, host.rd[0][7:0]}, 16'h005E);
    check({8'h00, host.rd[1][7:0]}, {8'h00, mem[8'h5A][7:0]});
    word_width_select = 1'b1;
    #200;
    chk_read(8'h59, 1, 0);
    done("byte mode");
    op(2'h0, lead(2'h0), 16'h0000);
    op(2'h1, 9'h020, 16'h1111);
    chk_read(8'h20, 1, 0);
    done("disable");
    print_verdict();
  end

  // Whole run is well under a millisecond; this cuts a hang short
  initial begin
    #2_000_000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // three_wire_serial_eeprom_tb
